// File: design/ivs_pkg.sv
// Purpose: constants for the interrupt vector, status and command block
// Assumes: 32-bit AXI4-Lite register bus, 32 interrupt sources
// Notes:   register offsets are full byte addresses on the bus
package ivs_pkg;

    // -----------------------------------------------------------------
    // sizes
    // -----------------------------------------------------------------
    localparam int IVS_ADDR_W = 32;
    localparam int IVS_DATA_W = 32;
    localparam int IVS_NUM_SRC = 32;
    localparam int IVS_IDX_W = 5;
    localparam int IVS_STRB_W = 4;

    // -----------------------------------------------------------------
    // register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [31:0] IVS_VEC_TABLE_BASE = 32'hFFFFF080;
    localparam logic [31:0] IVS_NORMAL_VECTOR_OUT = 32'hFFFFF100;
    localparam logic [31:0] IVS_FAST_VECTOR_OUT = 32'hFFFFF104;
    localparam logic [31:0] IVS_CURRENT_SOURCE_STATUS = 32'hFFFFF108;
    localparam logic [31:0] IVS_PENDING_FLAGS = 32'hFFFFF10C;
    localparam logic [31:0] IVS_ENABLE_STATE = 32'hFFFFF110;
    localparam logic [31:0] IVS_CORE_LINE_STATUS = 32'hFFFFF114;
    localparam logic [31:0] IVS_ENABLE_COMMAND = 32'hFFFFF120;
    localparam logic [31:0] IVS_DISABLE_COMMAND = 32'hFFFFF124;
    localparam logic [31:0] IVS_CLEAR_COMMAND = 32'hFFFFF128;
    localparam logic [31:0] IVS_SPURIOUS_VECTOR = 32'hFFFFF134;

    // -----------------------------------------------------------------
    // fields, reset values and bus answers
    // -----------------------------------------------------------------
    localparam logic [4:0] IVS_FAST_SOURCE = 5'h00;
    localparam logic [4:0] IVS_FIRST_NORMAL = 5'h01;
    localparam int IVS_FAST_LINE_BIT = 0;
    localparam int IVS_NORMAL_LINE_BIT = 1;
    localparam logic [31:0] IVS_RESET_WORD = 32'h00000000;
    localparam logic [1:0] IVS_RESP_OKAY = 2'h0;
    localparam logic [1:0] IVS_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IVS_RD_IDLE,
        IVS_RD_FETCH,
        IVS_RD_RESP
    } ivs_rd_state_type;

endpackage

// File: design/ivs_top.sv
// Purpose: vector, status and command registers of an interrupt controller
// Assumes: sources are high-active, synchronous to aclk, edge-captured
// Notes:   lowest-numbered pending enabled source 1..31 drives the normal
//          line; source 0 alone drives the fast line
//
// Summary of operation
// - normal vector read returns vector entry of the current interrupt
// - entry is chosen by the current interrupt number at read time
// - with no current interrupt, normal vector read returns spurious
// - fast vector read returns vector entry zero
// - with no fast interrupt, fast vector read returns spurious
// - status register reports the current source number
// - pending register: one bit per source, 1 while pending
// - mask register: one bit per source, 1 while enabled
// - core status bit 0 is 1 while the fast line is asserted
// - core status bit 1 is 1 while the normal line is asserted
// - enable command sets mask bits written as 1, others unchanged
// - disable command clears mask bits written as 1, others unchanged
// - clear command clears pending bits written as 1 unless a new edge sets them in the same cycle
`timescale 1ns/1ps
module ivs_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] src_in,
    output logic fast_request_line_n,
    output logic normal_request_line_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [31:0] pending_reg, pending_next;
    logic [31:0] mask_reg, mask_next;
    logic [31:0] src_prev_reg;
    logic [31:0] spu_reg;
    logic [4:0] cur_num_reg;
    logic fiq_n_reg, irq_n_reg;
    logic aw_have_reg, w_have_reg;
    logic [31:0] waddr_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic awready_reg, wready_reg, bvalid_reg;
    logic [1:0] bresp_reg;
    ivs_pkg::ivs_rd_state_type rd_state_reg, rd_state_next;
    logic [31:0] raddr_reg, rdata_reg;
    logic [1:0] rresp_reg;
    logic use_spu_reg;
    logic arready_reg, rvalid_reg;
    logic [31:0] mem_rd_data;

    // -----------------------------------------------------------------
    // source capture and interrupt selection
    // -----------------------------------------------------------------
    wire [31:0] src_rise = src_in & ~src_prev_reg;
    wire [31:0] active = pending_reg & mask_reg;
    wire fast_active = active[ivs_pkg::IVS_FAST_LINE_BIT];
    wire any_normal = |active[31:1];
    logic [4:0] pick_num;

    // lowest-numbered pending enabled normal source wins
    always_comb begin
        pick_num = ivs_pkg::IVS_FIRST_NORMAL;
        for (int i = ivs_pkg::IVS_NUM_SRC - 1; i >= 1; i--) begin
            if (active[i]) begin
                pick_num = 5'(i);
            end
        end
    end

    // -----------------------------------------------------------------
    // write channel decode
    // -----------------------------------------------------------------
    wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    wire [31:0] lane_mask;
    genvar g;
    generate
        for (g = 0; g < ivs_pkg::IVS_STRB_W; g++) begin : g_strb
            assign lane_mask[g*8 +: 8] = {8{wstrb_reg[g]}};
        end
    endgenerate
    wire [31:0] wword = wdata_reg & lane_mask;
    wire w_is_tab = (waddr_reg[31:7] == ivs_pkg::IVS_VEC_TABLE_BASE[31:7]);
    wire w_is_en = (waddr_reg[31:2] == ivs_pkg::IVS_ENABLE_COMMAND[31:2]);
    wire w_is_dis = (waddr_reg[31:2] == ivs_pkg::IVS_DISABLE_COMMAND[31:2]);
    wire w_is_clr = (waddr_reg[31:2] == ivs_pkg::IVS_CLEAR_COMMAND[31:2]);
    wire w_is_spu = (waddr_reg[31:2] == ivs_pkg::IVS_SPURIOUS_VECTOR[31:2]);
    wire w_is_ro =
        (waddr_reg[31:2] >= ivs_pkg::IVS_NORMAL_VECTOR_OUT[31:2]) &&
        (waddr_reg[31:2] <= ivs_pkg::IVS_CORE_LINE_STATUS[31:2]);
    wire w_mapped = w_is_tab || w_is_en || w_is_dis || w_is_clr ||
                    w_is_spu || w_is_ro;
    wire [31:0] en_word = (do_write && w_is_en) ? wword : 32'h00000000;
    wire [31:0] dis_word = (do_write && w_is_dis) ? wword : 32'h00000000;
    wire [31:0] clr_word = (do_write && w_is_clr) ? wword : 32'h00000000;

    // mask and pending next values; a new edge beats a clear
    assign mask_next = (mask_reg | en_word)
                       & ~dis_word;
    assign pending_next = (pending_reg & ~clr_word)
                          | src_rise;

    // -----------------------------------------------------------------
    // read channel decode
    // -----------------------------------------------------------------
    wire ar_take = s_axi_arvalid && arready_reg;
    wire [29:0] ar_word = s_axi_araddr[31:2];
    wire r_is_ivr = (ar_word == ivs_pkg::IVS_NORMAL_VECTOR_OUT[31:2]);
    wire r_is_fvr = (ar_word == ivs_pkg::IVS_FAST_VECTOR_OUT[31:2]);
    wire r_is_tab = (s_axi_araddr[31:7] == ivs_pkg::IVS_VEC_TABLE_BASE[31:7]);
    // vector entry chosen by current number at read time
    wire [4:0] rd_idx = r_is_ivr ? pick_num :
                        r_is_fvr ? ivs_pkg::IVS_FAST_SOURCE :
                        s_axi_araddr[6:2];
    wire rd_use_spu = (r_is_ivr && !any_normal) ||
                      (r_is_fvr && !fast_active);
    wire [29:0] rw = raddr_reg[31:2];
    wire rd_vec = (raddr_reg[31:7] == ivs_pkg::IVS_VEC_TABLE_BASE[31:7]) ||
                  (rw == ivs_pkg::IVS_NORMAL_VECTOR_OUT[31:2]) ||
                  (rw == ivs_pkg::IVS_FAST_VECTOR_OUT[31:2]);
    wire rd_wo = (rw == ivs_pkg::IVS_ENABLE_COMMAND[31:2]) ||
                 (rw == ivs_pkg::IVS_DISABLE_COMMAND[31:2]) ||
                 (rw == ivs_pkg::IVS_CLEAR_COMMAND[31:2]);
    logic [31:0] reg_word;
    logic reg_hit;

    // plain register read mux
    always_comb begin
        reg_word = ivs_pkg::IVS_RESET_WORD;
        reg_hit = 1'b1;
        if (rw == ivs_pkg::IVS_CURRENT_SOURCE_STATUS[31:2]) begin
            reg_word[4:0] = cur_num_reg;
        end else if (rw == ivs_pkg::IVS_PENDING_FLAGS[31:2]) begin
            reg_word = pending_reg;
        end else if (rw == ivs_pkg::IVS_ENABLE_STATE[31:2]) begin
            reg_word = mask_reg;
        end else if (rw == ivs_pkg::IVS_CORE_LINE_STATUS[31:2]) begin
            reg_word[ivs_pkg::IVS_FAST_LINE_BIT] = ~fiq_n_reg;
            reg_word[ivs_pkg::IVS_NORMAL_LINE_BIT] =
                ~irq_n_reg;
        end else if (rw == ivs_pkg::IVS_SPURIOUS_VECTOR[31:2]) begin
            reg_word = spu_reg;
        end else if (!rd_wo) begin
            reg_hit = 1'b0;
        end
    end

    // read state sequence: take, fetch table, answer
    always_comb begin
        case (rd_state_reg)
            ivs_pkg::IVS_RD_IDLE: begin
                rd_state_next = ar_take ? ivs_pkg::IVS_RD_FETCH
                                        : ivs_pkg::IVS_RD_IDLE;
            end
            ivs_pkg::IVS_RD_FETCH: begin
                rd_state_next = ivs_pkg::IVS_RD_RESP;
            end
            ivs_pkg::IVS_RD_RESP: begin
                rd_state_next = s_axi_rready ? ivs_pkg::IVS_RD_IDLE
                                             : ivs_pkg::IVS_RD_RESP;
            end
            default: begin
                rd_state_next = ivs_pkg::IVS_RD_IDLE;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // vector table
    // -----------------------------------------------------------------
    ivs_vec_mem u_vec_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(do_write && w_is_tab),
        .wr_idx(waddr_reg[6:2]),
        .wr_strb(wstrb_reg),
        .wr_data(wdata_reg),
        .rd_en(ar_take && (r_is_ivr || r_is_fvr || r_is_tab)),
        .rd_idx(rd_idx),
        .rd_data(mem_rd_data)
    );

    // -----------------------------------------------------------------
    // interrupt state and request lines
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_reg <= ivs_pkg::IVS_RESET_WORD;
            mask_reg <= ivs_pkg::IVS_RESET_WORD;
            src_prev_reg <= ivs_pkg::IVS_RESET_WORD;
            fiq_n_reg <= 1'b1;
            irq_n_reg <= 1'b1;
        end else begin
            pending_reg <= pending_next;
            mask_reg <= mask_next;
            src_prev_reg <= src_in;
            fiq_n_reg <= ~(pending_next[0] & mask_next[0]);
            irq_n_reg <= ~|(pending_next[31:1] & mask_next[31:1]);
        end
    end

    // current interrupt latched when the normal vector is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_num_reg <= ivs_pkg::IVS_FAST_SOURCE;
        end else if (ar_take && r_is_ivr) begin
            cur_num_reg <= any_normal ? pick_num : ivs_pkg::IVS_FAST_SOURCE;
        end
    end

    // spurious vector register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spu_reg <= ivs_pkg::IVS_RESET_WORD;
        end else if (do_write && w_is_spu) begin
            spu_reg <= (spu_reg & ~lane_mask) | wword;
        end
    end

    // -----------------------------------------------------------------
    // write channels: address and data in either order
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            waddr_reg <= ivs_pkg::IVS_RESET_WORD;
            wdata_reg <= ivs_pkg::IVS_RESET_WORD;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                aw_have_reg <= 1'b1;
                waddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    // write ready and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ivs_pkg::IVS_RESP_OKAY;
        end else begin
            awready_reg <= !aw_have_reg && !(s_axi_awvalid && awready_reg)
                           && !bvalid_reg && !do_write;
            wready_reg <= !w_have_reg && !(s_axi_wvalid && wready_reg)
                          && !bvalid_reg && !do_write;
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= w_mapped ? ivs_pkg::IVS_RESP_OKAY
                                      : ivs_pkg::IVS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // read channels
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_reg <= ivs_pkg::IVS_RD_IDLE;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            raddr_reg <= ivs_pkg::IVS_RESET_WORD;
            use_spu_reg <= 1'b0;
        end else begin
            rd_state_reg <= rd_state_next;
            arready_reg <= (rd_state_next == ivs_pkg::IVS_RD_IDLE);
            rvalid_reg <= (rd_state_next == ivs_pkg::IVS_RD_RESP);
            if (ar_take) begin
                raddr_reg <= s_axi_araddr;
                use_spu_reg <= rd_use_spu;
            end
        end
    end

    // answer data formed in the fetch cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_reg <= ivs_pkg::IVS_RESET_WORD;
            rresp_reg <= ivs_pkg::IVS_RESP_OKAY;
        end else if (rd_state_reg == ivs_pkg::IVS_RD_FETCH) begin
            rdata_reg <= !rd_vec ? reg_word :
                         use_spu_reg ? spu_reg : mem_rd_data;
            rresp_reg <= (rd_vec || reg_hit) ? ivs_pkg::IVS_RESP_OKAY
                                             : ivs_pkg::IVS_RESP_SLVERR;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign fast_request_line_n = fiq_n_reg;
    assign normal_request_line_n = irq_n_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_fast_line_level: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (pending_reg[0] && mask_reg[0]) |-> !fiq_n_reg)
        else $error("fast line not asserted for active fast source");

    a_normal_line_level: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (irq_n_reg == !any_normal))
        else $error("normal line disagrees with active sources");

    a_enable_sets_mask: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (do_write && w_is_en) |=> ((mask_reg & $past(wword)) == $past(wword)))
        else $error("enable command left a mask bit clear");

    a_disable_clears_mask: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (do_write && w_is_dis) |=> ((mask_reg & $past(wword)) == 32'h0))
        else $error("disable command left a mask bit set");

    a_clear_drops_pending: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (do_write && w_is_clr) |=>
            ((pending_reg & $past(wword) & ~$past(src_rise)) == 32'h0))
        else $error("clear command left a pending bit set");

    a_mask_after_reset: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(aresetn) |-> (mask_reg == 32'h0))
        else $error("mask not zero after reset");

    a_read_answer_time: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take |-> ##2 s_axi_rvalid)
        else $error("read answer not two cycles after address");

    a_spurious_normal: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ar_take && r_is_ivr && !any_normal && !(do_write && w_is_spu))
            |-> ##2 (s_axi_rdata == spu_reg))
        else $error("normal vector read without interrupt not spurious");

    a_spurious_fast: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ar_take && r_is_fvr && !fast_active && !(do_write && w_is_spu))
            |-> ##2 (s_axi_rdata == spu_reg))
        else $error("fast vector read without fast interrupt not spurious");

    a_current_number: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ar_take && r_is_ivr && any_normal) |=>
            (cur_num_reg == $past(pick_num)))
        else $error("current number not taken at normal vector read");

    c_normal_vector_read: cover property (@(posedge aclk)
        disable iff (!aresetn) ar_take && r_is_ivr && any_normal);
    c_fast_vector_read: cover property (@(posedge aclk)
        disable iff (!aresetn) ar_take && r_is_fvr && fast_active);
    c_clear_command: cover property (@(posedge aclk)
        disable iff (!aresetn) do_write && w_is_clr && |(wword & pending_reg));

endmodule

// File: design/ivs_vec_mem.sv
// Purpose: source vector table, one word per interrupt source
// Assumes: one write port with byte enables, one registered read port
// Notes:   read data appear one clock after rd_en
`timescale 1ns/1ps
module ivs_vec_mem (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_en,
    input wire logic [ivs_pkg::IVS_IDX_W-1:0] wr_idx,
    input wire logic [ivs_pkg::IVS_STRB_W-1:0] wr_strb,
    input wire logic [ivs_pkg::IVS_DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [ivs_pkg::IVS_IDX_W-1:0] rd_idx,
    output logic [ivs_pkg::IVS_DATA_W-1:0] rd_data
);

    logic [ivs_pkg::IVS_DATA_W-1:0] mem_reg [ivs_pkg::IVS_NUM_SRC];
    wire [ivs_pkg::IVS_DATA_W-1:0] wr_word;

    // -----------------------------------------------------------------
    // byte-lane writes
    // -----------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < ivs_pkg::IVS_STRB_W; b++) begin : g_lane
            // new byte where strobed, old byte of the entry otherwise
            assign wr_word[b*8 +: 8] = wr_strb[b] ? wr_data[b*8 +: 8]
                : mem_reg[wr_idx][b*8 +: 8];
        end
    endgenerate

    // one process owns the whole table, so no split drivers
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem_reg[wr_idx] <= wr_word;
        end
    end

    // -----------------------------------------------------------------
    // registered read
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data <= ivs_pkg::IVS_RESET_WORD;
        end else if (rd_en) begin
            rd_data <= mem_reg[rd_idx];
        end
    end

endmodule

// File: tb/ivs_core_model.sv
// Purpose: processor core side of the two request lines
// Assumes: core samples the lines on each rising edge
// Notes:   outputs are active-high copies for the bench
`timescale 1ns/1ps
module ivs_core_model (
    input wire logic aclk,
    input wire logic fast_request_line_n,
    input wire logic normal_request_line_n,
    output logic fast_seen,
    output logic normal_seen
);
    // sample the active-low lines once a clock
    always_ff @(posedge aclk) begin
        fast_seen <= !fast_request_line_n;
        normal_seen <= !normal_request_line_n;
    end
endmodule

// File: tb/ivs_top_bench.sv
// Purpose: self-checking bench for the vector, status and command block
// Assumes: AXI4-Lite master drives after rising edges
// Notes:   table entries use distinct marker vectors
`timescale 1ns/1ps
module ivs_top_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] src_in = 32'h00000000;
    logic [31:0] s_axi_awaddr = 32'h00000000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [31:0] s_axi_araddr = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, fast_request_line_n, normal_request_line_n;
    logic fast_seen, normal_seen;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int mismatches = 0;
    int cmp_count = 0;
    localparam logic [31:0] tab_base = ivs_pkg::IVS_VEC_TABLE_BASE;
    // clock at 40 MHz
    always #12.5 aclk = ~aclk;
    ivs_top dut_u (.aclk, .aresetn, .src_in, .fast_request_line_n,
        .normal_request_line_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ivs_core_model core_u (.aclk, .fast_request_line_n,
        .normal_request_line_n, .fast_seen, .normal_seen);
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bus write, holds each channel until taken; bready stays high
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, ivs_pkg::IVS_RESP_OKAY});
    endtask
    // bus read with data and response check
    task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                      input logic [1:0] er = ivs_pkg::IVS_RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // reset values, then spurious vector with nothing current
    task automatic t_spur();
        rd(ivs_pkg::IVS_ENABLE_STATE, 32'h00000000);
        rd(ivs_pkg::IVS_PENDING_FLAGS, 32'h00000000);
        rd(ivs_pkg::IVS_CORE_LINE_STATUS, 32'h00000000);
        wr(ivs_pkg::IVS_SPURIOUS_VECTOR, 32'h0000BEEF);
        rd(ivs_pkg::IVS_NORMAL_VECTOR_OUT, 32'h0000BEEF);
        rd(ivs_pkg::IVS_FAST_VECTOR_OUT, 32'h0000BEEF);
        $display("test spur done");
    endtask
    // sources 0, 3 and 5 raised and enabled
    task automatic t_active();
        wr(tab_base, 32'h0000A000);
        wr(tab_base + 32'hC, 32'h0000A030);
        wr(tab_base + 32'h14, 32'h0000A050);
        wr(ivs_pkg::IVS_ENABLE_COMMAND, 32'h00000029);
        src_in <= 32'h00000029;
        rd(ivs_pkg::IVS_PENDING_FLAGS, 32'h00000029);
        rd(ivs_pkg::IVS_ENABLE_STATE, 32'h00000029);
        rd(ivs_pkg::IVS_CORE_LINE_STATUS, 32'h00000003);
        chk({30'h0, fast_seen, normal_seen}, 32'h00000003);
        rd(ivs_pkg::IVS_NORMAL_VECTOR_OUT, 32'h0000A030);
        rd(ivs_pkg::IVS_CURRENT_SOURCE_STATUS, 32'h00000003);
        rd(ivs_pkg::IVS_FAST_VECTOR_OUT, 32'h0000A000);
        $display("test active done");
    endtask
    // clear 0 and 3, mask history on source 5, byte strobes
    task automatic t_cmds();
        wr(ivs_pkg::IVS_CLEAR_COMMAND, 32'h00000009);
        rd(ivs_pkg::IVS_PENDING_FLAGS, 32'h00000020);
        rd(ivs_pkg::IVS_CORE_LINE_STATUS, 32'h00000002);
        chk({30'h0, fast_seen, normal_seen}, 32'h00000001);
        rd(ivs_pkg::IVS_FAST_VECTOR_OUT, 32'h0000BEEF);
        rd(ivs_pkg::IVS_NORMAL_VECTOR_OUT, 32'h0000A050);
        rd(ivs_pkg::IVS_CURRENT_SOURCE_STATUS, 32'h00000005);
        wr(ivs_pkg::IVS_DISABLE_COMMAND, 32'h00000020);
        rd(ivs_pkg::IVS_ENABLE_STATE, 32'h00000009);
        rd(ivs_pkg::IVS_CORE_LINE_STATUS, 32'h00000000);
        wr(ivs_pkg::IVS_ENABLE_COMMAND, 32'h00000020);
        rd(ivs_pkg::IVS_ENABLE_STATE, 32'h00000029);
        rd(ivs_pkg::IVS_CORE_LINE_STATUS, 32'h00000002);
        wr(ivs_pkg::IVS_DISABLE_COMMAND, 32'h00000021);
        rd(ivs_pkg::IVS_NORMAL_VECTOR_OUT, 32'h0000BEEF);
        rd(32'hFFFFF118, 32'h00000000, ivs_pkg::IVS_RESP_SLVERR);
        rd(tab_base + 32'h14, 32'h0000A050);
        wr(ivs_pkg::IVS_SPURIOUS_VECTOR, 32'h12345678, 4'h3);
        rd(ivs_pkg::IVS_SPURIOUS_VECTOR, 32'h00005678);
        rd(ivs_pkg::IVS_NORMAL_VECTOR_OUT, 32'h00005678);
        $display("test commands done");
    endtask
    // reset in mid-run clears mask, pending, lines and spurious vector
    task automatic t_rst();
        src_in <= 32'h00000000;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ivs_pkg::IVS_ENABLE_STATE, 32'h00000000);
        rd(ivs_pkg::IVS_PENDING_FLAGS, 32'h00000000);
        rd(ivs_pkg::IVS_CORE_LINE_STATUS, 32'h00000000);
        chk({30'h0, fast_seen, normal_seen}, 32'h00000000);
        rd(ivs_pkg::IVS_SPURIOUS_VECTOR, 32'h00000000);
        $display("test reset done");
    endtask
    // verdict and end of run
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        #(25 * 5000);
        mismatches++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_spur();
        t_active();
        t_cmds();
        t_rst();
        complete_run();
    end
endmodule
